// [fspc_core_model.sv]
/* Core model: issues store and load pulses with pointer and data.
   Assumes tasks are called at a rising edge of aclk. */
`timescale 1ns/1ps
`default_nettype none
module fspc_core_model (
  input wire logic aclk,
  input wire logic core_stall,
  input wire logic load_data_valid,
  input wire logic [7:0] load_data,
  output var logic store_pulse,
  output var logic load_pulse,
  output var logic [15:0] pointer_in,
  output var logic [15:0] source_word_pair
);
  // ===
  // store and load
  initial begin
    store_pulse = 1'b0;
    load_pulse = 1'b0;
    pointer_in = 16'h0000;
    source_word_pair = 16'h0000;
  end
  // released lines show the inverse so a stale latch cannot pass
  task automatic store(input logic [15:0] p, input logic [15:0] d);
    while (core_stall) @(posedge aclk);
    pointer_in <= p;
    source_word_pair <= d;
    store_pulse <= 1'b1;
    @(posedge aclk);
    store_pulse <= 1'b0;
    pointer_in <= ~p;
    source_word_pair <= ~d;
  endtask
  task automatic load(input logic [15:0] p, output logic v, output logic [7:0] d);
    pointer_in <= p;
    load_pulse <= 1'b1;
    @(posedge aclk);
    load_pulse <= 1'b0;
    pointer_in <= ~p;
    @(posedge aclk);
    v = load_data_valid;
    d = load_data;
  endtask
endmodule // fspc_core_model
`default_nettype wire

// [fspc_defines.vh]
/*
  Constants for the flash self-program control block: register offsets,
  control/status bit positions, reset values and timing windows.
  Assumes inclusion by bare name from the design file.
*/
`ifndef FSPC_DEFINES_VH
`define FSPC_DEFINES_VH

// ==========================================================
// register byte offsets
`define FSPC_OFF_CTRL 8'h00
`define FSPC_OFF_PTR 8'h04
`define FSPC_OFF_DATA 8'h08
`define FSPC_OFF_STAT 8'h0C
`define FSPC_OFF_OP 8'h10

// ==========================================================
// control/status bit positions
`define FSPC_B_IE 7
`define FSPC_B_BUSY 6
`define FSPC_B_SIG 5
`define FSPC_B_RRE 4
`define FSPC_B_LOCK 3
`define FSPC_B_PWR 2
`define FSPC_B_PER 1
`define FSPC_B_EN 0

// ==========================================================
// command patterns, low five bits
// 10001 is the re-enable pattern; a signature read shares 00001 with a fill and
// is told apart by the signature bit above the five command bits
`define FSPC_CMD_RRE 5'h11
`define FSPC_CMD_LOCK 5'h09
`define FSPC_CMD_PWR 5'h05
`define FSPC_CMD_PER 5'h03
`define FSPC_CMD_FILL 5'h01

// ==========================================================
// reset values and windows
`define FSPC_CTRL_RST 8'h00
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3
`define FSPC_APP_RESET 16'h0000
`define FSPC_RESP_OKAY 2'h0
`define FSPC_RESP_SLVERR 2'h2

`endif

// [fspc_monitor.sv]
/* Port checker for fspc_top.
   Assumes a bind from the testbench and the single aclk domain. */
`timescale 1ns/1ps
`default_nettype none
module fspc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic store_pulse,
  input wire logic load_pulse,
  input wire logic eeprom_busy,
  input wire logic global_irq_flag,
  input wire logic [15:0] source_word_pair,
  input wire logic [15:0] reset_fetch_addr,
  input wire logic ready_irq,
  input wire logic core_stall,
  input wire logic rww_read_block,
  input wire logic load_data_valid,
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire logic lock_write_start,
  input wire logic [7:0] lock_write_data
);
  // ===
  // properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // margin for the two-flop sync plus the command register
  sequence s_ee_held; eeprom_busy [*5]; endsequence
  sequence s_store_seen; $past(store_pulse) || $past(store_pulse, 2); endsequence
  property p_fetch_fixed; aresetn [*4] |-> $stable(reset_fetch_addr); endproperty
  property p_irq_cause; ready_irq |-> $past(global_irq_flag); endproperty
  property p_busy_set; $rose(rww_read_block) |-> s_store_seen; endproperty
  property p_stall_set; core_stall && !$past(core_stall) |-> s_store_seen; endproperty
  property p_erase_cause; flash_erase_start |-> $past(store_pulse) ##1 !flash_erase_start;
  endproperty
  property p_write_cause; flash_write_start |-> $past(store_pulse); endproperty
  property p_lock_data;
    lock_write_start |-> $past(store_pulse) && lock_write_data == $past(source_word_pair[7:0]);
  endproperty
  property p_load_cause; load_data_valid |-> $past(load_pulse); endproperty
  property p_ee_block;
    s_ee_held |-> !flash_erase_start && !flash_write_start && !lock_write_start;
  endproperty
  a_fetch_fixed: assert property (p_fetch_fixed)
    else $error("fetch address changed");
  a_irq_cause: assert property (p_irq_cause)
    else $error("ready request without global flag");
  a_busy_set: assert property (p_busy_set)
    else $error("busy rose without store");
  a_stall_set: assert property (p_stall_set)
    else $error("stall rose without store");
  a_erase_cause: assert property (p_erase_cause)
    else $error("bad erase start");
  a_write_cause: assert property (p_write_cause)
    else $error("write start without store");
  a_lock_data: assert property (p_lock_data)
    else $error("bad lock write");
  a_load_cause: assert property (p_load_cause)
    else $error("load answer without load");
  a_ee_block: assert property (p_ee_block)
    else $error("program start while eeprom busy");
endmodule // fspc_monitor
`default_nettype wire

// [fspc_top.v]
/*
  Flash self-programming control: control/status register, armed command
  windows, page buffer, busy tracking and ready request, with an AXI4-Lite
  register slave. Assumes the core issues store/load pulses on aclk and
  that the flash array reports completion with flash_done.
*/
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defines.vh"

// Function
// - reset fetch address chosen by boot fuse
// - no write path to fuse values
// - ready request while enable bit clear
// - busy flag set on rww-section program
// - busy cleared by re-enable or fill
// - re-enable store; ignored while programming runs
// - re-enable during fill discards buffer
// - lock store programs lock bits from low
// - lock load returns lock or fuse
// - signature load returns byte; store nothing
// - page write store uses page field
// - page erase store uses page field
// - stall core on protected-section program
// - fill store writes word pair buffer
// - enable arms four cycles for stores, three for loads, auto-clears
// - only five patterns act
// - pointer split and latched at start
// - load pointer low bit picks byte
// - buffer cleared after write, re-enable, reset
// - eeprom write blocks program and reads
module fspc_top #(
  parameter WORD_BITS = 5,
  parameter PAGE_BITS = 11,
  parameter NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 11'h060,
  parameter BOOT_START = 16'h0C00,
  parameter SIG_BYTE = 8'h5A  // arbitrary value
) (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire boot_vector_fuse,
  input wire [7:0] fuse_low_bits,
  input wire [7:0] lock_bits_now,
  input wire store_pulse,
  input wire load_pulse,
  input wire [15:0] pointer_in,
  input wire [15:0] source_word_pair,
  input wire global_irq_flag,
  input wire eeprom_busy,
  input wire flash_done,
  output reg [15:0] reset_fetch_addr,
  output reg ready_irq,
  output reg core_stall,
  output reg rww_read_block,
  output reg load_data_valid,
  output reg [7:0] load_data,
  output reg flash_erase_start,
  output reg flash_write_start,
  output reg lock_write_start,
  output reg [7:0] lock_write_data,
  output reg [PAGE_BITS-1:0] flash_page,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam DEPTH = 1 << WORD_BITS;

  // ==========================================================
  // input synchronisers for pins from outside the clock domain
  reg fuse_s1_reg, fuse_s2_reg, ee_s1_reg, ee_s2_reg;

  // fuse syncs keep running through reset: the boot choice is made at the
  // first edge after release and must see the settled pin, not a reset value
  always @(posedge aclk) begin
    if (clk_en) begin
      fuse_s1_reg <= boot_vector_fuse;
      fuse_s2_reg <= fuse_s1_reg;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ee_s1_reg <= 1'b0;
      ee_s2_reg <= 1'b0;
    end else if (clk_en) begin
      ee_s1_reg <= eeprom_busy;
      ee_s2_reg <= ee_s1_reg;
    end
  end

  // ==========================================================
  // state
  reg [7:0] ctrl_reg;
  reg [2:0] win_reg;
  reg prog_reg;
  reg fill_reg;
  reg [DEPTH-1:0] filled_reg;
  reg [15:0] buf_mem [0:DEPTH-1];
  reg [15:0] ptr_reg;
  reg [15:0] data_reg;
  reg reset_seen_reg;
  reg aw_hold_reg, w_hold_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire [4:0] cmd = ctrl_reg[4:0];
  wire armed = ctrl_reg[`FSPC_B_EN] && !prog_reg && (win_reg != 3'h0);
  wire [PAGE_BITS-1:0] page_sel = pointer_in[15:16-PAGE_BITS];
  wire [WORD_BITS-1:0] word_sel = pointer_in[WORD_BITS:1];
  wire do_store = store_pulse && armed && !ee_s2_reg;
  wire do_load = load_pulse && armed && (win_reg > 3'h1) && !ee_s2_reg;
  // signature read: fill pattern plus the signature bit; stores are ignored
  wire sig_rd = ctrl_reg[`FSPC_B_SIG] && (cmd == `FSPC_CMD_FILL);

  // ==========================================================
  // register bus write capture
  wire wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (aw_addr_reg == `FSPC_OFF_CTRL) && w_strb_reg[0];
  wire [7:0] wv = w_data_reg[7:0];
  wire wr_arm = wr_ctrl && !prog_reg && !ee_s2_reg && wv[`FSPC_B_EN];
  // the four plain command patterns; re-enable is decoded on its own below,
  // because it has side effects on the page buffer at write time
  wire wr_cmd_ok = (wv[4:0] == `FSPC_CMD_LOCK) ||
                   (wv[4:0] == `FSPC_CMD_PWR) || (wv[4:0] == `FSPC_CMD_PER) ||
                   (wv[4:0] == `FSPC_CMD_FILL);
  // re-enable is refused while programming runs: wr_arm already holds !prog_reg
  wire wr_reenable = wr_arm && (wv[4:0] == `FSPC_CMD_RRE) && !wv[`FSPC_B_SIG];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FSPC_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg <= `FSPC_OFF_OP && aw_addr_reg[1:0] == 2'h0) ?
                       `FSPC_RESP_OKAY : `FSPC_RESP_SLVERR;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control/status, windows, buffer and flash commands
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `FSPC_CTRL_RST;
      win_reg <= 3'h0;
      prog_reg <= 1'b0;
      fill_reg <= 1'b0;
      filled_reg <= {DEPTH{1'b0}};
      ptr_reg <= 16'h0000;
      data_reg <= 16'h0000;
      flash_erase_start <= 1'b0;
      flash_write_start <= 1'b0;
      lock_write_start <= 1'b0;
      lock_write_data <= 8'h00;
      flash_page <= {PAGE_BITS{1'b0}};
      core_stall <= 1'b0;
      load_data_valid <= 1'b0;
      load_data <= 8'h00;
    end else if (clk_en) begin
      flash_erase_start <= 1'b0;
      flash_write_start <= 1'b0;
      lock_write_start <= 1'b0;
      load_data_valid <= 1'b0;
      if (wr_go && aw_addr_reg == `FSPC_OFF_PTR) ptr_reg <= w_data_reg[15:0];
      if (wr_go && aw_addr_reg == `FSPC_OFF_DATA) data_reg <= w_data_reg[15:0];
      if (wr_ctrl) ctrl_reg[`FSPC_B_IE] <= wv[`FSPC_B_IE];
      if (wr_arm && wr_cmd_ok) begin
        ctrl_reg[5:0] <= {wv[5], 1'b0, wv[3:0]} | {1'b0, ctrl_reg[`FSPC_B_BUSY], 4'h0};
        ctrl_reg[`FSPC_B_RRE] <= 1'b0;
        win_reg <= `FSPC_STORE_WIN;
      end else if (wr_reenable) begin
        ctrl_reg[`FSPC_B_RRE] <= 1'b1;
        ctrl_reg[`FSPC_B_EN] <= 1'b1;
        win_reg <= `FSPC_STORE_WIN;
        if (fill_reg) begin
          filled_reg <= {DEPTH{1'b0}};
          fill_reg <= 1'b0;
        end
      end else if (prog_reg) begin
        if (flash_done) begin
          prog_reg <= 1'b0;
          core_stall <= 1'b0;
          ctrl_reg[4:0] <= 5'h00;
          if (ctrl_reg[`FSPC_B_PWR]) filled_reg <= {DEPTH{1'b0}};
        end
      end else if (do_store) begin
        win_reg <= 3'h0;
        ctrl_reg[`FSPC_B_EN] <= 1'b0;
        ctrl_reg[`FSPC_B_SIG] <= 1'b0;
        ctrl_reg[3:1] <= 3'h0;
        ctrl_reg[`FSPC_B_RRE] <= 1'b0;
        if (ctrl_reg[`FSPC_B_RRE]) begin
          ctrl_reg[`FSPC_B_BUSY] <= 1'b0;
          filled_reg <= {DEPTH{1'b0}};
          fill_reg <= 1'b0;
        end else if (cmd == `FSPC_CMD_PER || cmd == `FSPC_CMD_PWR) begin
          flash_page <= page_sel;
          flash_erase_start <= (cmd == `FSPC_CMD_PER);
          flash_write_start <= (cmd == `FSPC_CMD_PWR);
          prog_reg <= 1'b1;
          ctrl_reg[`FSPC_B_EN] <= 1'b1;
          ctrl_reg[3:1] <= ctrl_reg[3:1];
          if (page_sel >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) core_stall <= 1'b1;
          else ctrl_reg[`FSPC_B_BUSY] <= 1'b1;
        end else if (cmd == `FSPC_CMD_LOCK) begin
          lock_write_start <= 1'b1;
          lock_write_data <= source_word_pair[7:0];
        end else if (cmd == `FSPC_CMD_FILL && !ctrl_reg[`FSPC_B_SIG]) begin
          // a fill also ends the section block, so software can load the
          // next page without a separate re-enable
          ctrl_reg[`FSPC_B_BUSY] <= 1'b0;
          fill_reg <= 1'b1;
          buf_mem[word_sel] <= source_word_pair;
          filled_reg[word_sel] <= 1'b1;
        end
      end else if (do_load && (cmd == `FSPC_CMD_LOCK || sig_rd)) begin
        // busy sits at bit 6, outside this slice, so it survives the clear
        win_reg <= 3'h0;
        ctrl_reg[5:0] <= 6'h00;
        load_data_valid <= 1'b1;
        if (sig_rd) load_data <= SIG_BYTE;
        else load_data <= pointer_in[0] ? lock_bits_now : fuse_low_bits;
      end else if (win_reg != 3'h0) begin
        win_reg <= win_reg - 3'h1;
        if (win_reg == 3'h1) begin
          ctrl_reg[5:0] <= {1'b0, ctrl_reg[`FSPC_B_BUSY], 4'h0};
          ctrl_reg[`FSPC_B_RRE] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // buffer readback for the data register and the status outputs
  // words never filled since the last clear read as erased flash; the
  // filled mask is what gets cleared, the array itself keeps old contents
  // so a clear costs one cycle regardless of page size
  wire [15:0] buf_word = filled_reg[ptr_reg[WORD_BITS:1]] ?
                         buf_mem[ptr_reg[WORD_BITS:1]] : 16'hFFFF;
  wire [7:0] buf_byte = ptr_reg[0] ? buf_word[15:8] : buf_word[7:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      reset_seen_reg <= 1'b0;
      reset_fetch_addr <= `FSPC_APP_RESET;
      ready_irq <= 1'b0;
      rww_read_block <= 1'b0;
    end else if (clk_en) begin
      // fuse is only sampled, never written: no core path reaches it
      if (!reset_seen_reg) begin
        reset_seen_reg <= 1'b1;
        reset_fetch_addr <= fuse_s2_reg ? `FSPC_APP_RESET : BOOT_START;
      end
      ready_irq <= ctrl_reg[`FSPC_B_IE] && global_irq_flag &&
                   !ctrl_reg[`FSPC_B_EN];
      rww_read_block <= ctrl_reg[`FSPC_B_BUSY];
    end
  end

  // ==========================================================
  // register bus read
  // one read at a time: arready stays low while rvalid waits for rready
  // unmapped offsets answer with an error code and zero data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FSPC_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `FSPC_RESP_OKAY;
        case (s_axi_araddr[7:0])
          `FSPC_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_reg};
          `FSPC_OFF_PTR: s_axi_rdata <= {16'h0000, ptr_reg};
          `FSPC_OFF_DATA: s_axi_rdata <= {24'h000000, buf_byte};
          `FSPC_OFF_STAT: s_axi_rdata <= {27'h0, ee_s2_reg, fill_reg, core_stall,
                                          prog_reg, !fuse_s2_reg};
          `FSPC_OFF_OP: s_axi_rdata <= {16'h0000, reset_fetch_addr};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FSPC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // fspc_top
`default_nettype wire

// [tb.sv]
/* Testbench for fspc_top with core model and AXI4-Lite master tasks.
   Assumes fspc_monitor and fspc_core_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) total_checks++; if ((a) !== (e)) begin error_cnt++; $display("wrong value %s expected %h seen %h", n, e, a); end
module tb;
  localparam logic [15:0] BOOT = 16'h0C00;
  localparam logic [7:0] SIG = 8'hC3; // arbitrary value
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, boot_vector_fuse = 1'b1;
  logic global_irq_flag = 1'b1, eeprom_busy = 1'b0, flash_done = 1'b0;
  logic [7:0] fuse_low_bits = 8'h6E, lock_bits_now = 8'hE9, load_data, lock_write_data, b;
  logic store_pulse, load_pulse, ready_irq, core_stall, rww_read_block, load_data_valid, v;
  logic flash_erase_start, flash_write_start, lock_write_start;
  logic [15:0] pointer_in, source_word_pair, reset_fetch_addr;
  logic [10:0] flash_page;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int error_cnt = 0, total_checks = 0;
  initial forever #10 aclk = ~aclk;
  fspc_top #(.BOOT_START(BOOT), .SIG_BYTE(SIG)) i_fspc_top (.aclk, .aresetn, .clk_en,
    .boot_vector_fuse, .fuse_low_bits, .lock_bits_now, .store_pulse, .load_pulse, .pointer_in,
    .source_word_pair, .global_irq_flag, .eeprom_busy, .flash_done, .reset_fetch_addr,
    .ready_irq, .core_stall, .rww_read_block, .load_data_valid, .load_data, .flash_erase_start,
    .flash_write_start, .lock_write_start, .lock_write_data, .flash_page, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fspc_core_model i_fspc_core_model (.aclk, .core_stall, .load_data_valid, .load_data,
    .store_pulse, .load_pulse, .pointer_in, .source_word_pair);
  // ===
  // bus and helper tasks
  // ready lines stay high after first use; each call drives them high again
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    r = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic reset_to(input logic f);
    aresetn <= 1'b0;
    boot_vector_fuse <= f;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  task automatic done_pulse;
    flash_done <= 1'b1;
    @(posedge aclk);
    flash_done <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic no_start(input logic [7:0] c, input logic [3:0] s, input int w);
    axw(8'h00, c, s);
    repeat (w) @(posedge aclk);
    i_fspc_core_model.store(16'h0140, 16'h0000);
    @(posedge aclk);
    `CHK("no start", 3'b000, {flash_erase_start, flash_write_start, lock_write_start})
  endtask
  // ===
  // scenarios
  task automatic t_reset;
    reset_to(1'b0);
    `CHK("fetch boot", BOOT, reset_fetch_addr)
    reset_to(1'b1);
    `CHK("fetch app", 16'h0000, reset_fetch_addr)
    axr(8'h00);
    `CHK("ctrl reset", 32'h0, r)
    axr(8'h14);
    `CHK("unmapped", 2'h2, rr)
    $display("test reset done");
  endtask
  task automatic t_rww;
    axw(8'h00, 8'h83, 4'hF);
    i_fspc_core_model.store(16'h0140, 16'h1234);
    @(posedge aclk);
    `CHK("erase start", 1'b1, flash_erase_start)
    `CHK("erase page", 11'h00A, flash_page)
    @(posedge aclk);
    `CHK("busy", 1'b1, rww_read_block)
    `CHK("no stall", 1'b0, core_stall)
    `CHK("irq held", 1'b0, ready_irq)
    axr(8'h00);
    `CHK("ctrl busy", 32'hC3, r)
    done_pulse;
    axr(8'h00);
    `CHK("ctrl done", 32'hC0, r)
    `CHK("irq", 1'b1, ready_irq)
    axw(8'h00, 8'h11, 4'hF);
    i_fspc_core_model.store(16'h0140, 16'h0000);
    repeat (2) @(posedge aclk);
    `CHK("busy clear", 1'b0, rww_read_block)
    $display("test rww erase done");
  endtask
  task automatic t_no_read_while_write_section;
    axw(8'h00, 8'h05, 4'hF);
    i_fspc_core_model.store(16'h0C20, 16'h0000);
    @(posedge aclk);
    `CHK("write start", 1'b1, flash_write_start)
    `CHK("write page", 11'h061, flash_page)
    @(posedge aclk);
    `CHK("stall", 1'b1, core_stall)
    `CHK("no busy", 1'b0, rww_read_block)
    done_pulse;
    `CHK("stall drop", 1'b0, core_stall)
    $display("test no_read_while_write_section write done");
  endtask
  task automatic t_lock;
    axw(8'h00, 8'h09, 4'hF);
    i_fspc_core_model.load(16'h0001, v, b);
    `CHK("lock valid", 1'b1, v)
    `CHK("lock byte", 8'hE9, b)
    axw(8'h00, 8'h09, 4'hF);
    i_fspc_core_model.load(16'h0000, v, b);
    `CHK("fuse byte", 8'h6E, b)
    axw(8'h00, 8'h21, 4'hF);
    i_fspc_core_model.load(16'h0000, v, b);
    `CHK("sig byte", SIG, b)
    no_start(8'h21, 4'hF, 0);
    axw(8'h00, 8'h09, 4'hF);
    i_fspc_core_model.store(16'h0140, 16'hFFC3);
    @(posedge aclk);
    `CHK("lock start", 1'b1, lock_write_start)
    `CHK("lock data", 8'hC3, lock_write_data)
    $display("test lock done");
  endtask
  task automatic t_fill;
    axw(8'h00, 8'h01, 4'hF);
    i_fspc_core_model.store(16'h0006, 16'hBEEF);
    axw(8'h04, 8'h07, 4'hF);
    axr(8'h08);
    `CHK("fill high byte", 32'hBE, r)
    axw(8'h00, 8'h11, 4'hF);
    i_fspc_core_model.store(16'h0000, 16'h0000);
    axr(8'h08);
    `CHK("buffer cleared", 32'hFF, r)
    $display("test fill done");
  endtask
  task automatic t_refuse;
    no_start(8'h07, 4'hF, 0);
    no_start(8'h03, 4'h0, 0);
    no_start(8'h03, 4'hF, 6);
    eeprom_busy <= 1'b1;
    no_start(8'h03, 4'hF, 0);
    eeprom_busy <= 1'b0;
    repeat (8) @(posedge aclk);
    $display("test refuse done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    @(posedge aclk);
    t_reset;
    t_rww;
    t_no_read_while_write_section;
    t_lock;
    t_fill;
    t_refuse;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    finish_test;
  end
endmodule // tb
bind fspc_top fspc_monitor i_fspc_monitor (.aclk, .aresetn, .store_pulse, .load_pulse,
  .eeprom_busy, .global_irq_flag, .source_word_pair, .reset_fetch_addr, .ready_irq,
  .core_stall, .rww_read_block, .load_data_valid, .flash_erase_start, .flash_write_start,
  .lock_write_start, .lock_write_data);
`default_nettype wire
